// >>> logic/oais_pkg.sv
package oais_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] OAIS_ADDR_STATUS = 8'h00; // Primary event status, read clears
    localparam logic [7:0] OAIS_ADDR_FIFO_DATA = 8'h08; // FIFO data port (read strobe only)
    localparam logic [7:0] OAIS_ADDR_FENCE_SEL = 8'h70; // Fence slot select
    localparam logic [7:0] OAIS_ADDR_IRQ1_A = 8'h78; // Output one enables, bank a
    localparam logic [7:0] OAIS_ADDR_IRQ1_B = 8'h79;
    localparam logic [7:0] OAIS_ADDR_IRQ1_C = 8'h7a;
    localparam logic [7:0] OAIS_ADDR_IRQ2_A = 8'h7c; // Output two enables, bank a
    localparam logic [7:0] OAIS_ADDR_IRQ2_B = 8'h7d;
    localparam logic [7:0] OAIS_ADDR_IRQ2_C = 8'h7e;
    localparam logic [7:0] OAIS_ADDR_LOW_LIM2 = 8'h6d; // Second lower limit
    localparam logic [7:0] OAIS_ADDR_FENCE_CFG = 8'h71; // Fence filter config

    // ------------------------------------------------------------------
    // Status bit positions
    // ------------------------------------------------------------------
    localparam int OAIS_BIT_AFULL = 7;
    localparam int OAIS_BIT_FRAME = 6;
    localparam int OAIS_BIT_NEWDATA = 5;
    localparam int OAIS_BIT_AMB_OVF = 4;
    localparam int OAIS_BIT_EXPOSURE = 3;
    localparam int OAIS_BIT_LIM2 = 2;
    localparam int OAIS_BIT_LIM1 = 1;
    localparam int OAIS_BIT_SUPPLY = 0;

    // ------------------------------------------------------------------
    // Reset values and range limits
    // ------------------------------------------------------------------
    localparam logic [7:0] OAIS_STATUS_RST = 8'h01; // Dropout flag set at power-on
    localparam logic [7:0] OAIS_REG_RST = 8'h00;
    localparam logic signed [19:0] OAIS_POS_FULL = 20'sh7ffff; // Over-range code
    localparam logic signed [19:0] OAIS_NEG_QUARTER = 20'she0000; // Under-range limit
    localparam int OAIS_SLOTS = 9;

    // Host port access strobe bundle
    typedef struct packed {
        logic rd; // One-cycle read strobe
        logic wr; // One-cycle write strobe
        logic [7:0] addr;
        logic [7:0] wdata;
    } oais_host_s;

    // Per-measurement event bundle from the acquisition core
    typedef struct packed {
        logic valid; // One-cycle result strobe
        logic ambient; // Result is a dark-current measurement
        logic signed [19:0] code;
    } oais_result_s;
endpackage

// >>> logic/oais_irq_status.sv
// Behaviour
// - Set almost-full when FIFO count reaches threshold
// - Clear almost-full on status or data read
// - Set frame-complete when all enabled slots done
// - Set new-sample on each FIFO write
// - Clear frame/new-sample on status or data read
// - Ambient overflow sets on range fault, read clears
// - Over-range at full scale, under below quarter
// - Exposure overflow sets on range fault, read clears
// - Forward-biased photodiode also sets exposure overflow
// - Supply dropout unmaskable; read or shutdown clears
`timescale 1ns/1ns
`default_nettype none
module oais_irq_status
    import oais_pkg::*;
#(
    parameter int FIFO_CNT_W = 8,
    parameter int SLOTS = OAIS_SLOTS
) (
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire oais_host_s host,
    output logic [7:0] rdata_r,
    input wire logic [FIFO_CNT_W-1:0] fifo_count,
    input wire logic [7:0] fifo_afull_level,
    input wire logic fifo_push,
    input wire logic [SLOTS-1:0] slot_enable,
    input wire logic [SLOTS-1:0] slot_done,
    input wire oais_result_s result,
    input wire logic pd_forward_bias,
    input wire logic limit1_crossed,
    input wire logic limit2_crossed,
    input wire logic data_read_clears_flags,
    input wire logic shutdown_control,
    output logic irq_out_one_r,
    output logic irq_out_two_r
);
    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0] status_r; // Sticky event flags
    logic [7:0] status_nxt;
    logic [7:0] en1_a_r, en1_b_r, en1_c_r; // Output one enables
    logic [7:0] en2_a_r, en2_b_r, en2_c_r; // Output two enables
    logic [7:0] fence_sel_r, low_lim2_r, fence_cfg_r; // Storage only
    logic [SLOTS-1:0] done_seen_r; // Slots finished in this frame
    logic [SLOTS-1:0] done_seen_nxt;
    logic afull_prev_r; // Previous threshold compare for edge
    logic [7:0] rdata_nxt;

    // ------------------------------------------------------------------
    // Decode and events
    // ------------------------------------------------------------------
    wire status_rd = host.rd && (host.addr == OAIS_ADDR_STATUS);
    wire data_rd = host.rd && (host.addr == OAIS_ADDR_FIFO_DATA);
    wire data_clr = data_rd && data_read_clears_flags;
    // Edge of the threshold compare, so one fill event sets once
    // Both sides widened so any count width compares without a zero replication
    wire afull_now = (32'(fifo_count) >= 32'(fifo_afull_level));
    wire afull_set = afull_now && !afull_prev_r;
    wire [SLOTS-1:0] done_all = done_seen_r | slot_done;
    // Empty sequence never completes a frame
    wire frame_set = (|slot_enable) && ((done_all & slot_enable) == slot_enable);
    wire code_over = (result.code == OAIS_POS_FULL);
    wire code_under = (result.code < OAIS_NEG_QUARTER);
    wire range_bad = result.valid && (code_over || code_under);
    wire amb_set = range_bad && result.ambient;
    wire exp_set = (range_bad && !result.ambient) || pd_forward_bias;
    wire [7:0] set_vec = {afull_set, frame_set, fifo_push, amb_set, exp_set,
        limit2_crossed, limit1_crossed, 1'b0};
    // Bits cleared by the optional data read path
    wire [7:0] data_mask = 8'he0;
    wire [7:0] clr_vec = (status_rd ? 8'hff : 8'h00) | (data_clr ? data_mask : 8'h00) |
        (shutdown_control ? 8'h01 : 8'h00);
    // Dropout bypasses both enable banks
    wire irq1_nxt = |(status_nxt & en1_a_r & 8'hfe) ||
        status_nxt[OAIS_BIT_SUPPLY];
    wire irq2_nxt = |(status_nxt & en2_a_r & 8'hfe) ||
        status_nxt[OAIS_BIT_SUPPLY];

    // Set wins over a clear in the same cycle
    assign status_nxt = (status_r & ~clr_vec) | set_vec;
    assign done_seen_nxt = frame_set ? '0 : done_all;

    // Read mux; unmapped addresses return zero
    always_comb begin
        unique case (host.addr)
            OAIS_ADDR_STATUS: rdata_nxt = status_r;
            OAIS_ADDR_FENCE_SEL: rdata_nxt = fence_sel_r;
            OAIS_ADDR_FENCE_CFG: rdata_nxt = fence_cfg_r;
            OAIS_ADDR_LOW_LIM2: rdata_nxt = low_lim2_r;
            OAIS_ADDR_IRQ1_A: rdata_nxt = en1_a_r;
            OAIS_ADDR_IRQ1_B: rdata_nxt = en1_b_r;
            OAIS_ADDR_IRQ1_C: rdata_nxt = en1_c_r;
            OAIS_ADDR_IRQ2_A: rdata_nxt = en2_a_r;
            OAIS_ADDR_IRQ2_B: rdata_nxt = en2_b_r;
            OAIS_ADDR_IRQ2_C: rdata_nxt = en2_c_r;
            default: rdata_nxt = 8'h00;
        endcase
    end

    // ------------------------------------------------------------------
    // Status and outputs
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            status_r <= OAIS_STATUS_RST;
            done_seen_r <= '0;
            afull_prev_r <= 1'b0;
            rdata_r <= OAIS_REG_RST;
            irq_out_one_r <= OAIS_STATUS_RST[OAIS_BIT_SUPPLY];
            irq_out_two_r <= OAIS_STATUS_RST[OAIS_BIT_SUPPLY];
        end else begin
            status_r <= status_nxt;
            done_seen_r <= done_seen_nxt;
            afull_prev_r <= afull_now;
            rdata_r <= host.rd ? rdata_nxt : rdata_r;
            irq_out_one_r <= irq1_nxt;
            irq_out_two_r <= irq2_nxt;
        end
    end

    // Writable registers; status is read-only
    always_ff @(posedge sys_clk or negedge rst_b) begin
        if (!rst_b) begin
            {en1_a_r, en1_b_r, en1_c_r} <= {3{OAIS_REG_RST}};
            {en2_a_r, en2_b_r, en2_c_r} <= {3{OAIS_REG_RST}};
            {fence_sel_r, low_lim2_r, fence_cfg_r} <= {3{OAIS_REG_RST}};
        end else if (host.wr) begin
            if (host.addr == OAIS_ADDR_IRQ1_A) en1_a_r <= host.wdata;
            if (host.addr == OAIS_ADDR_IRQ1_B) en1_b_r <= host.wdata;
            if (host.addr == OAIS_ADDR_IRQ1_C) en1_c_r <= host.wdata;
            if (host.addr == OAIS_ADDR_IRQ2_A) en2_a_r <= host.wdata;
            if (host.addr == OAIS_ADDR_IRQ2_B) en2_b_r <= host.wdata;
            if (host.addr == OAIS_ADDR_IRQ2_C) en2_c_r <= host.wdata;
            if (host.addr == OAIS_ADDR_FENCE_SEL) fence_sel_r <= host.wdata;
            if (host.addr == OAIS_ADDR_LOW_LIM2) low_lim2_r <= host.wdata;
            if (host.addr == OAIS_ADDR_FENCE_CFG) fence_cfg_r <= host.wdata;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    // Status read empties the register when nothing new arrives
    property p_status_clear;
        @(posedge sys_clk) disable iff (!rst_b)
        status_rd && !(|set_vec) |=> status_r == 8'h00;
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("status not cleared");

    // Enabled data-port read drops the three FIFO flags
    property p_data_clear;
        @(posedge sys_clk) disable iff (!rst_b)
        data_clr && !afull_set && !frame_set && !fifo_push |=> status_r[7:5] == 3'b000;
    endproperty
    a_data_clear: assert property (p_data_clear) else $error("data read left flags");

    // Without the clear setting a data read must lose no FIFO flag
    property p_data_keep;
        @(posedge sys_clk) disable iff (!rst_b)
        data_rd && !data_read_clears_flags |=> ($past(status_r[7:5]) & ~status_r[7:5]) == 3'b000;
    endproperty
    a_data_keep: assert property (p_data_keep) else $error("flag lost on data read");

    // Every FIFO write raises new-sample
    property p_push_sets;
        @(posedge sys_clk) disable iff (!rst_b)
        fifo_push |=> status_r[OAIS_BIT_NEWDATA];
    endproperty
    a_push_sets: assert property (p_push_sets) else $error("new-sample not set");

    // Positive full scale on a dark result is an overflow
    property p_over;
        @(posedge sys_clk) disable iff (!rst_b)
        result.valid && result.ambient && result.code == 20'sh7ffff |=> status_r[4];
    endproperty
    a_over: assert property (p_over) else $error("ambient over-range missed");

    // Exactly the quarter-scale code is still in range for both kinds
    property p_under;
        @(posedge sys_clk) disable iff (!rst_b)
        (status_r[4:3] == 2'b00) && result.valid && result.code == OAIS_NEG_QUARTER
        && !pd_forward_bias |=> status_r[4:3] == 2'b00;
    endproperty
    a_under: assert property (p_under) else $error("quarter scale flagged");

    // Forward bias needs no result strobe to set the flag
    property p_fwd;
        @(posedge sys_clk) disable iff (!rst_b)
        pd_forward_bias |=> status_r[OAIS_BIT_EXPOSURE];
    endproperty
    a_fwd: assert property (p_fwd) else $error("forward bias missed");

    // Dropout reaches both outputs whatever the banks hold
    property p_dropout;
        @(posedge sys_clk) disable iff (!rst_b)
        status_r[0] |-> irq_out_one_r && irq_out_two_r;
    endproperty
    a_dropout: assert property (p_dropout) else $error("dropout not on outputs");

    // Output one changes on the same edge as the flags it gates
    property p_irq_follow;
        @(posedge sys_clk) disable iff (!rst_b)
        ##1 irq_out_one_r == (|($past(status_nxt) & $past(en1_a_r) & 8'hfe)
        || $past(status_nxt[0]));
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("output one wrong");

    // Output two tracks its own bank the same way
    property p_irq2_follow;
        @(posedge sys_clk) disable iff (!rst_b)
        ##1 irq_out_two_r == (|($past(status_nxt) & $past(en2_a_r) & 8'hfe)
        || $past(status_nxt[0]));
    endproperty
    a_irq2_follow: assert property (p_irq2_follow) else $error("output two wrong");

    // Crossing the threshold sets almost-full on the next edge
    property p_afull;
        @(posedge sys_clk) disable iff (!rst_b)
        afull_now && !afull_prev_r |=> status_r[7];
    endproperty
    a_afull: assert property (p_afull) else $error("almost-full not set");
endmodule
`default_nettype wire

// >>> test/oais_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------
// Host processor model on the register strobes
// ------------------------------------------------------------
module oais_host_model
    import oais_pkg::*;
(
    input wire logic sys_clk,
    output var oais_host_s host,
    input wire logic [7:0] rdata_r
);
    // Idle bus carries junk so stale address use shows up
    initial host = '{rd: 1'b0, wr: 1'b0, addr: 8'h5a, wdata: 8'ha5};

    // One write strobe, held across one sampling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        host <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge sys_clk);
        host <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    endtask

    // Read strobe; answer stands from the strobe edge, taken one edge later
    // so callers always resume on a rising edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        host <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge sys_clk);
        host <= '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: 8'hff};
        @(posedge sys_clk);
        d = rdata_r;
    endtask

    // Interrupt service: find pending sources and clear them
    task automatic service(output logic [7:0] d);
        rd(OAIS_ADDR_STATUS, d);
    endtask
endmodule
`default_nettype wire

// >>> test/test_optical_afe_irq_status.sv
`timescale 1ns/1ns
`default_nettype none
module test_optical_afe_irq_status;
    import oais_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------------------------
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    oais_host_s host;
    logic [7:0] rdata_r;
    logic [7:0] fifo_count = 8'h00;
    logic [7:0] fifo_afull_level = 8'h10;
    logic fifo_push = 1'b0;
    logic [8:0] slot_enable = 9'h101;
    logic [8:0] slot_done = 9'h000;
    oais_result_s result = '0;
    logic pd_forward_bias = 1'b0;
    logic limit1_crossed = 1'b0;
    logic limit2_crossed = 1'b0;
    logic data_read_clears_flags = 1'b0;
    logic shutdown_control = 1'b0;
    logic irq1;
    logic irq2;
    int num_errors = 0;
    int checks = 0;
    // Mapped read/write places, then range table {ambient, code}
    logic [7:0] rw_addr [9] = '{OAIS_ADDR_IRQ1_A, OAIS_ADDR_IRQ1_B, OAIS_ADDR_IRQ1_C,
        OAIS_ADDR_IRQ2_A, OAIS_ADDR_IRQ2_B, OAIS_ADDR_IRQ2_C, OAIS_ADDR_FENCE_SEL,
        OAIS_ADDR_LOW_LIM2, OAIS_ADDR_FENCE_CFG};
    logic [20:0] rng [7] = '{21'h17ffff, 21'h17fffe, 21'h1e0000, 21'h1dffff,
        21'h07ffff, 21'h0dffff, 21'h000000};
    logic [7:0] rng_exp [7] = '{8'h10, 8'h00, 8'h00, 8'h10, 8'h08, 8'h08, 8'h00};

    always #20 sys_clk = ~sys_clk;

    oais_host_model hm (.sys_clk(sys_clk), .host(host), .rdata_r(rdata_r));

    oais_irq_status #(.FIFO_CNT_W(8), .SLOTS(9)) dut (.sys_clk(sys_clk), .rst_b(rst_b),
        .host(host), .rdata_r(rdata_r), .fifo_count(fifo_count),
        .fifo_afull_level(fifo_afull_level), .fifo_push(fifo_push),
        .slot_enable(slot_enable), .slot_done(slot_done), .result(result),
        .pd_forward_bias(pd_forward_bias), .limit1_crossed(limit1_crossed),
        .limit2_crossed(limit2_crossed), .data_read_clears_flags(data_read_clears_flags),
        .shutdown_control(shutdown_control), .irq_out_one_r(irq1), .irq_out_two_r(irq2));

    // ------------------------------------------------------------
    // Shared helpers
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // Waits edges; two after a pulse lets flag and output both settle
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Status read through the host's service routine
    task automatic stat(input string n, input logic [7:0] exp);
        logic [7:0] d;
        hm.service(d);
        chk(n, d, exp);
    endtask

    // Single place where the run ends
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Watchdog: the tests need well under a thousand cycles
    initial begin
        #(4000 * 40);
        num_errors++;
        final_report();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] d;
        tick(5);
        rst_b <= 1'b1;
        tick(1);
        chk("irq one at reset", {7'h00, irq1}, 8'h01);
        chk("irq two at reset", {7'h00, irq2}, 8'h01);
        stat("status at reset", OAIS_STATUS_RST);
        chk("irq one after read", {7'h00, irq1}, 8'h00);
        $display("test reset done");
        // Reset values, storage, refused places
        foreach (rw_addr[i]) begin
            hm.rd(rw_addr[i], d);
            chk("reg reset value", d, OAIS_REG_RST);
            hm.wr(rw_addr[i], 8'h3c ^ 8'(i));
            hm.rd(rw_addr[i], d);
            chk("reg readback", d, 8'h3c ^ 8'(i));
        end
        hm.rd(8'h30, d);
        chk("unmapped read", d, 8'h00);
        hm.wr(OAIS_ADDR_STATUS, 8'hff);
        stat("status write ignored", 8'h00);
        hm.wr(OAIS_ADDR_IRQ1_A, 8'h80);
        hm.wr(OAIS_ADDR_IRQ2_A, 8'h18);
        $display("test registers done");
        // Almost-full at exactly the threshold, routed to output one only
        fifo_count <= 8'h10;
        tick(3);
        chk("irq one afull", {7'h00, irq1}, 8'h01);
        chk("irq two afull", {7'h00, irq2}, 8'h00);
        stat("status afull", 8'h80);
        chk("irq one released", {7'h00, irq1}, 8'h00);
        fifo_count <= 8'h00;
        // Data-port read clears only the FIFO flags, and only when enabled
        for (int m = 0; m < 2; m++) begin
            data_read_clears_flags <= (m == 0);
            fifo_push <= 1'b1;
            limit1_crossed <= 1'b1;
            limit2_crossed <= (m == 1);
            tick(1);
            fifo_push <= 1'b0;
            limit1_crossed <= 1'b0;
            limit2_crossed <= 1'b0;
            tick(2);
            hm.rd(OAIS_ADDR_FIFO_DATA, d);
            chk("fifo data read", d, 8'h00);
            stat("status after data read", (m == 0) ? 8'h02 : 8'h26);
        end
        $display("test fifo flags done");
        // Frame completes only when both enabled slots have finished
        slot_done <= 9'h001;
        tick(1);
        slot_done <= 9'h000;
        stat("frame partial", 8'h00);
        slot_done <= 9'h100;
        tick(1);
        slot_done <= 9'h000;
        tick(2);
        stat("frame complete", 8'h40);
        // Range limits on dark and exposure results
        foreach (rng[i]) begin
            result <= '{valid: 1'b1, ambient: rng[i][20], code: rng[i][19:0]};
            tick(1);
            result.valid <= 1'b0;
            tick(2);
            chk("irq two range", {7'h00, irq2}, {7'h00, |rng_exp[i]});
            stat("range flag", rng_exp[i]);
        end
        pd_forward_bias <= 1'b1;
        tick(1);
        pd_forward_bias <= 1'b0;
        tick(2);
        stat("forward bias", 8'h08);
        $display("test overflow done");
        // Second reset, then shutdown clears the dropout flag
        rst_b <= 1'b0;
        tick(2);
        rst_b <= 1'b1;
        shutdown_control <= 1'b1;
        tick(1);
        shutdown_control <= 1'b0;
        tick(2);
        chk("irq one after shutdown", {7'h00, irq1}, 8'h00);
        stat("status after shutdown", 8'h00);
        $display("test shutdown done");
        final_report();
    end
endmodule
`default_nettype wire
